// *** gspwm_pkg.sv ***
// constants and carrier types of the grayscale pwm latch block
// assumes one core clock; all pin levels arrive unsynchronised
package gspwm_pkg;

  // ----------------------------------------------------------------
  // grayscale word layout
  // ----------------------------------------------------------------
  localparam int GS_WORD_W = 288;
  localparam int CH_VAL_W = 12;
  localparam int GROUP_W = 36;
  localparam int GROUPS = 8;
  localparam int RED_LSB = 0;
  localparam int RSV_LSB = 12;
  localparam int BLUE_LSB = 24;
  localparam int CFG_W = 205;

  // ----------------------------------------------------------------
  // counter and width modes
  // ----------------------------------------------------------------
  localparam int CNT_W = 13;
  localparam int MODE_W = 2;
  localparam logic [MODE_W-1:0] MODE_10 = 2'h2;
  localparam logic [MODE_W-1:0] MODE_8 = 2'h3;
  localparam logic [CNT_W-1:0] CNT_ZERO = 13'h0000;
  localparam logic [CNT_W-1:0] CNT_ONE = 13'h0001;
  localparam logic [CNT_W-1:0] CNT_MAX_12 = 13'h1000;
  localparam logic [CNT_W-1:0] CNT_MAX_10 = 13'h0400;
  localparam logic [CNT_W-1:0] CNT_MAX_8 = 13'h0100;
  localparam logic [CH_VAL_W-1:0] MASK_12 = 12'hFFF;
  localparam logic [CH_VAL_W-1:0] MASK_10 = 12'h3FF;
  localparam logic [CH_VAL_W-1:0] MASK_8 = 12'h0FF;

  // ----------------------------------------------------------------
  // reset values
  // ----------------------------------------------------------------
  localparam logic [GS_WORD_W-1:0] SR_RESET = 288'h0;
  localparam logic [CH_VAL_W-1:0] GS_RESET = 12'h000;

  // ----------------------------------------------------------------
  // carrier of the host-driven pins
  // ----------------------------------------------------------------
  typedef struct packed {
    logic shift_clk;
    logic serial_data_in;
    logic latch;
    logic blank;
    logic grayscale_ref_clock;
  } gspwm_pins_t;

endpackage : gspwm_pkg

// *** gspwm_chan.sv ***
// one channel comparator of the grayscale pwm latch
// assumes count and value come from logic on the same clock
`timescale 1ns/1ps

module gspwm_chan (
  // grayscale value and width mode
  input wire logic [gspwm_pkg::CH_VAL_W-1:0] grayscale_value_i,
  input wire logic [gspwm_pkg::MODE_W-1:0] counter_width_select_i,
  // shared counter
  input wire logic [gspwm_pkg::CNT_W-1:0] count_i,
  // output enable for this channel
  output logic on_o
);

  // ----------------------------------------------------------------
  // width masking
  // ----------------------------------------------------------------
  logic [gspwm_pkg::CH_VAL_W-1:0] mask;
  logic [gspwm_pkg::CH_VAL_W-1:0] used_value;
  logic [gspwm_pkg::CNT_W-1:0] wide_value;

  assign mask = (counter_width_select_i == gspwm_pkg::MODE_8) ? gspwm_pkg::MASK_8 :
                (counter_width_select_i == gspwm_pkg::MODE_10) ? gspwm_pkg::MASK_10 :
                gspwm_pkg::MASK_12;
  assign used_value = grayscale_value_i & mask;
  assign wide_value = {1'b0, used_value};

  // ----------------------------------------------------------------
  // compare
  // ----------------------------------------------------------------
  // on from count one up to the value, off once the count passes it
  assign on_o = (count_i != gspwm_pkg::CNT_ZERO) && (count_i <= wide_value);

endmodule : gspwm_chan

// *** gspwm_latch.sv ***
// grayscale shift register, data latch, shared counter and channel pwm
// assumes host pins are asynchronous and much slower than core_clk_i;
// config readback data and width select come from logic on core_clk_i
//
// Overview of operation
// - grayscale word is 288 bits, one 12-bit value per channel plus reserved slots.
// - latch rising edge copies the red and blue values of the shift register into the grayscale latch.
// - newly latched values drive the output comparisons immediately.
// - counter steps by one per grayscale clock rising edge while blank is high, until it parks at the full period.
// - blank falling clears the counter; it stays zero while blank is low.
// - first grayscale clock edge after blank rises makes the count one, outputs with a nonzero value on.
// - channel stays on while count is at most its value.
// - channel goes off when count first exceeds value; zero gives no on-time.
// - 4096 steps in 12-bit mode, 1024 in 10-bit, 256 in 8-bit; on-time is value clock periods, duty value over the step count.
// - reset clears shift register and grayscale latch.
// - after each latch, config data loads into the lowest 205 shift bits.
// - each 36-bit group holds blue value, reserved slot, red value, top down.
// - 10-bit or 8-bit mode compares only the low 10 or 8 value bits.
`timescale 1ns/1ps

module gspwm_latch #(
  parameter int CHANNELS_PER_GROUP = gspwm_pkg::GROUPS
) (
  // clock and reset
  input wire logic core_clk_i,
  input wire logic sys_rst_i,
  // host pins
  input wire gspwm_pkg::gspwm_pins_t pins_i,
  // readback and mode from the config latch
  input wire logic [gspwm_pkg::CFG_W-1:0] function_brightness_dot_config_i,
  input wire logic [gspwm_pkg::MODE_W-1:0] counter_width_select_i,
  // serial output
  output logic serial_data_out_o,
  // channel enables
  output logic [CHANNELS_PER_GROUP-1:0] blue_group_channel_o,
  output logic [CHANNELS_PER_GROUP-1:0] red_group_channel_o,
  // counter state
  output logic [gspwm_pkg::CNT_W-1:0] gs_count_o
);

  // ----------------------------------------------------------------
  // pin synchronisers and edges
  // ----------------------------------------------------------------
  gspwm_pkg::gspwm_pins_t pins_meta;
  gspwm_pkg::gspwm_pins_t pins_sync;
  gspwm_pkg::gspwm_pins_t pins_prev;

  always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      pins_meta <= '0;
      pins_sync <= '0;
      pins_prev <= '0;
    end else begin
      pins_meta <= pins_i;
      pins_sync <= pins_meta;
      pins_prev <= pins_sync;
    end
  end

  logic shift_rise;
  logic latch_rise;
  logic grayscale_ref_clock_rise;
  logic blank_high;
  logic blank_fall;

  assign shift_rise = pins_sync.shift_clk & ~pins_prev.shift_clk;
  assign latch_rise = pins_sync.latch & ~pins_prev.latch;
  assign grayscale_ref_clock_rise = pins_sync.grayscale_ref_clock & ~pins_prev.grayscale_ref_clock;
  assign blank_high = pins_sync.blank;
  assign blank_fall = pins_prev.blank & ~pins_sync.blank;

  // ----------------------------------------------------------------
  // common shift register
  // ----------------------------------------------------------------
  logic [gspwm_pkg::GS_WORD_W-1:0] shift_reg;
  logic [gspwm_pkg::GS_WORD_W-1:0] shifted;
  logic [gspwm_pkg::GS_WORD_W-1:0] readback;
  logic [gspwm_pkg::GS_WORD_W-1:0] next_shift_reg;

  // data enters at the bottom and leaves from the top
  assign shifted = {shift_reg[gspwm_pkg::GS_WORD_W-2:0], pins_sync.serial_data_in};
  assign readback = {shift_reg[gspwm_pkg::GS_WORD_W-1:gspwm_pkg::CFG_W],
                     function_brightness_dot_config_i};
  // a latch edge wins over a shift edge in the same cycle
  assign next_shift_reg = latch_rise ? readback :
                          shift_rise ? shifted : shift_reg;

  always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      shift_reg <= gspwm_pkg::SR_RESET;
    end else begin
      shift_reg <= next_shift_reg;
    end
  end

  // ----------------------------------------------------------------
  // grayscale data latch
  // ----------------------------------------------------------------
  // reserved slots are never stored
  logic [CHANNELS_PER_GROUP-1:0][gspwm_pkg::CH_VAL_W-1:0] red_value;
  logic [CHANNELS_PER_GROUP-1:0][gspwm_pkg::CH_VAL_W-1:0] blue_value;
  logic [CHANNELS_PER_GROUP-1:0][gspwm_pkg::CH_VAL_W-1:0] next_red_value;
  logic [CHANNELS_PER_GROUP-1:0][gspwm_pkg::CH_VAL_W-1:0] next_blue_value;

  // ----------------------------------------------------------------
  // shared grayscale counter
  // ----------------------------------------------------------------
  logic [gspwm_pkg::CNT_W-1:0] count;
  logic [gspwm_pkg::CNT_W-1:0] count_max;
  logic [gspwm_pkg::CNT_W-1:0] count_inc;
  logic [gspwm_pkg::CNT_W-1:0] next_count;
  logic count_step;

  // full period of the selected width; count parks there, all off
  assign count_max = (counter_width_select_i == gspwm_pkg::MODE_8) ? gspwm_pkg::CNT_MAX_8 :
                     (counter_width_select_i == gspwm_pkg::MODE_10) ? gspwm_pkg::CNT_MAX_10 :
                     gspwm_pkg::CNT_MAX_12;
  assign count_step = blank_high && grayscale_ref_clock_rise && (count < count_max);
  assign count_inc = count + gspwm_pkg::CNT_ONE;
  assign next_count = !blank_high ? gspwm_pkg::CNT_ZERO :
                      count_step ? count_inc :
                      (count > count_max) ? count_max : count;

  // ----------------------------------------------------------------
  // channel comparators
  // ----------------------------------------------------------------
  logic [CHANNELS_PER_GROUP-1:0] next_red_on;
  logic [CHANNELS_PER_GROUP-1:0] next_blue_on;

  genvar g;
  generate
    for (g = 0; g < CHANNELS_PER_GROUP; g++) begin : gen_group
      localparam int BASE = g * gspwm_pkg::GROUP_W;
      localparam int RED_LO = BASE + gspwm_pkg::RED_LSB;
      localparam int BLUE_LO = BASE + gspwm_pkg::BLUE_LSB;

      // new values go straight to the comparators
      assign next_red_value[g] = latch_rise ?
        shift_reg[RED_LO +: gspwm_pkg::CH_VAL_W] : red_value[g];
      assign next_blue_value[g] = latch_rise ?
        shift_reg[BLUE_LO +: gspwm_pkg::CH_VAL_W] : blue_value[g];

      gspwm_chan u_red (
        .grayscale_value_i(next_red_value[g]),
        .counter_width_select_i(counter_width_select_i),
        .count_i(next_count),
        .on_o(next_red_on[g])
      );

      gspwm_chan u_blue (
        .grayscale_value_i(next_blue_value[g]),
        .counter_width_select_i(counter_width_select_i),
        .count_i(next_count),
        .on_o(next_blue_on[g])
      );
    end
  endgenerate

  // ----------------------------------------------------------------
  // state and output flops
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      red_value <= {CHANNELS_PER_GROUP{gspwm_pkg::GS_RESET}};
      blue_value <= {CHANNELS_PER_GROUP{gspwm_pkg::GS_RESET}};
      count <= gspwm_pkg::CNT_ZERO;
      gs_count_o <= gspwm_pkg::CNT_ZERO;
      red_group_channel_o <= '0;
      blue_group_channel_o <= '0;
      serial_data_out_o <= 1'b0;
    end else begin
      red_value <= next_red_value;
      blue_value <= next_blue_value;
      count <= next_count;
      gs_count_o <= next_count;
      red_group_channel_o <= next_red_on;
      blue_group_channel_o <= next_blue_on;
      serial_data_out_o <= next_shift_reg[gspwm_pkg::GS_WORD_W-1];
    end
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  logic [gspwm_pkg::CNT_W-1:0] red0_wide;
  logic [gspwm_pkg::CNT_W-1:0] blue7_wide;

  assign red0_wide = {1'b0, red_value[0]};
  assign blue7_wide = {1'b0, blue_value[CHANNELS_PER_GROUP-1]};

  latch_copy_a: assert property (
    @(posedge core_clk_i) disable iff (sys_rst_i)
    latch_rise |=> (red_value[0] == $past(shift_reg[11:0]))
      && (blue_value[CHANNELS_PER_GROUP-1] == $past(shift_reg[287:276])))
    else $error("latch did not copy the shift register");

  config_load_a: assert property (
    @(posedge core_clk_i) disable iff (sys_rst_i)
    latch_rise |=> (shift_reg[204:0] == $past(function_brightness_dot_config_i))
      && (shift_reg[287:205] == $past(shift_reg[287:205])))
    else $error("config readback not loaded after latch");

  shift_in_a: assert property (
    @(posedge core_clk_i) disable iff (sys_rst_i)
    (shift_rise && !latch_rise) |=> (shift_reg[0] == $past(pins_sync.serial_data_in))
      && (shift_reg[287:1] == $past(shift_reg[286:0])))
    else $error("shift register did not advance");

  blank_clear_a: assert property (
    @(posedge core_clk_i) disable iff (sys_rst_i)
    (blank_fall or !blank_high) |=> (count == 13'h0000) && (gs_count_o == 13'h0000))
    else $error("counter not held at zero while blank low");

  count_step_a: assert property (
    @(posedge core_clk_i) disable iff (sys_rst_i)
    (blank_high && grayscale_ref_clock_rise && count < count_max) |=> (count == $past(count) + 13'h0001))
    else $error("counter did not step on grayscale clock");

  count_hold_a: assert property (
    @(posedge core_clk_i) disable iff (sys_rst_i)
    (blank_high && !grayscale_ref_clock_rise && $stable(counter_width_select_i) && count <= count_max)
      |=> (count == $past(count)))
    else $error("counter moved without a grayscale clock edge");

  first_edge_a: assert property (
    @(posedge core_clk_i) disable iff (sys_rst_i)
    (count == 13'h0000 && blank_high && grayscale_ref_clock_rise && red_value[0] != 12'h000
      && counter_width_select_i[1] == 1'b0 && !latch_rise)
      |=> (count == 13'h0001) && red_group_channel_o[0])
    else $error("first edge after blank did not start the on-period");

  no_wrap_a: assert property (
    @(posedge core_clk_i) disable iff (sys_rst_i)
    (count == count_max && blank_high && $stable(counter_width_select_i))
      |=> (count == $past(count)) && (red_group_channel_o == '0)
      && (blue_group_channel_o == '0))
    else $error("counter wrapped or output on at full period");

  red_compare_a: assert property (
    @(posedge core_clk_i) disable iff (sys_rst_i)
    (counter_width_select_i[1] == 1'b0)
      |-> (red_group_channel_o[0] == ((count != 13'h0000) && (count <= red0_wide))))
    else $error("red channel 0 enable disagrees with count");

  blue_compare_a: assert property (
    @(posedge core_clk_i) disable iff (sys_rst_i)
    (latch_rise && counter_width_select_i[1] == 1'b0)
      |=> (blue_group_channel_o[CHANNELS_PER_GROUP-1]
        == ((count != 13'h0000) && (count <= blue7_wide))))
    else $error("new value not applied at once");

  zero_value_a: assert property (
    @(posedge core_clk_i) disable iff (sys_rst_i)
    (red_value[0] == 12'h000) |-> !red_group_channel_o[0])
    else $error("zero value produced on-time");

  narrow_mode_a: assert property (
    @(posedge core_clk_i) disable iff (sys_rst_i)
    (counter_width_select_i == 2'h3 && count != 13'h0000)
      |-> (red_group_channel_o[0] == (count <= {5'h00, red_value[0][7:0]})))
    else $error("8-bit mode used upper value bits");

  reset_clear_a: assert property (
    @(posedge core_clk_i)
    $fell(sys_rst_i) |-> (shift_reg == 288'h0) && (red_value[0] == 12'h000))
    else $error("reset did not clear shift register and latch");

  value_hold_a: assert property (
    @(posedge core_clk_i) disable iff (sys_rst_i)
    !latch_rise |=> $stable(red_value) && $stable(blue_value))
    else $error("latched values changed without a latch edge");

  shift_hold_a: assert property (
    @(posedge core_clk_i) disable iff (sys_rst_i)
    (!shift_rise && !latch_rise) |=> $stable(shift_reg))
    else $error("shift register moved without a shift edge");

  sdo_top_a: assert property (
    @(posedge core_clk_i) disable iff (sys_rst_i)
    serial_data_out_o == shift_reg[gspwm_pkg::GS_WORD_W-1])
    else $error("serial output is not the top shift bit");

  zero_count_off_a: assert property (
    @(posedge core_clk_i) disable iff (sys_rst_i)
    (count == gspwm_pkg::CNT_ZERO)
      |-> (red_group_channel_o == '0) && (blue_group_channel_o == '0))
    else $error("channel on while count is zero");

  count_bound_a: assert property (
    @(posedge core_clk_i) disable iff (sys_rst_i)
    $stable(counter_width_select_i) |-> (count <= count_max))
    else $error("counter beyond its full period");

  width_ten_a: assert property (
    @(posedge core_clk_i) disable iff (sys_rst_i)
    (counter_width_select_i == gspwm_pkg::MODE_10) && $stable(counter_width_select_i)
      && (count != gspwm_pkg::CNT_ZERO)
      |-> (blue_group_channel_o[0] == (count <= {3'h0, blue_value[0][9:0]})))
    else $error("10-bit mode used upper value bits");

endmodule : gspwm_latch

// *** gspwm_host.sv ***
// host-side model: drives shift, latch, blank and grayscale clock pins
// assumes the bench calls its tasks; every pin level is held >= 2 core cycles
`timescale 1ns/1ps

module gspwm_host (
  // core clock used only for pacing
  input wire logic core_clk_i,
  // host pins
  output gspwm_pkg::gspwm_pins_t pins_o
);
  initial pins_o = '0;

  task automatic wait_cyc(input int n);
    repeat (n) @(posedge core_clk_i);
    #1;
  endtask : wait_cyc

  // data settles before the shift clock rises
  task automatic shift_bit(input logic b);
    pins_o.serial_data_in = b;
    wait_cyc(2);
    pins_o.shift_clk = 1'b1;
    wait_cyc(3);
    pins_o.shift_clk = 1'b0;
    wait_cyc(2);
  endtask : shift_bit

  // msb first, so bit 287 lands on top
  task automatic shift_word(input logic [287:0] w);
    for (int i = 287; i >= 0; i--) begin
      shift_bit(w[i]);
    end
  endtask : shift_word

  // normally issued while blank is low
  task automatic pulse_latch();
    pins_o.latch = 1'b1;
    wait_cyc(3);
    pins_o.latch = 1'b0;
    wait_cyc(3);
  endtask : pulse_latch

  task automatic set_blank(input logic b);
    pins_o.blank = b;
    wait_cyc(4);
  endtask : set_blank

  task automatic grayscale_ref_clock_pulses(input int n);
    repeat (n) begin
      pins_o.grayscale_ref_clock = 1'b1;
      wait_cyc(3);
      pins_o.grayscale_ref_clock = 1'b0;
      wait_cyc(3);
    end
  endtask : grayscale_ref_clock_pulses
endmodule : gspwm_host

// *** grayscale_pwm_latch_tb_top.sv ***
// self-checking bench of the grayscale pwm latch
// assumes gspwm_host as the pin driver and the default channel count
`timescale 1ns/1ps

module grayscale_pwm_latch_tb_top;
  logic core_clk_i;
  logic sys_rst_i;
  gspwm_pkg::gspwm_pins_t pins;
  logic [gspwm_pkg::CFG_W-1:0] cfg;
  logic [1:0] mode;
  logic serial_data_out;
  logic [7:0] blue_o;
  logic [7:0] red_o;
  logic [12:0] cnt;
  logic [11:0] red_v [8];
  logic [11:0] blue_v [8];
  int err_count;
  int cmp_count;

  initial begin
    core_clk_i = 1'b0;
    forever #5 core_clk_i = ~core_clk_i;
  end

  gspwm_host i_host (.core_clk_i(core_clk_i), .pins_o(pins));

  gspwm_latch i_dut (
    .core_clk_i(core_clk_i),
    .sys_rst_i(sys_rst_i),
    .pins_i(pins),
    .function_brightness_dot_config_i(cfg),
    .counter_width_select_i(mode),
    .serial_data_out_o(serial_data_out),
    .blue_group_channel_o(blue_o),
    .red_group_channel_o(red_o),
    .gs_count_o(cnt)
  );

  task automatic chk(input logic [287:0] seen, input logic [287:0] exp, input string msg);
    cmp_count++;
    if (seen !== exp) begin
      err_count++;
      $display("unexpected at %0t: %s", $time, msg);
    end
  endtask : chk

  task automatic finish_test();
    $display("checks %0d, mismatches %0d", cmp_count, err_count);
    if (err_count == 0 && cmp_count > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : finish_test

  // reserved slots filled with ones on purpose
  function automatic logic [287:0] mk_word();
    logic [287:0] w;
    for (int g = 0; g < 8; g++) begin
      w[36*g +: 12] = red_v[g];
      w[36*g+12 +: 12] = 12'hFFF;
      w[36*g+24 +: 12] = blue_v[g];
    end
    return w;
  endfunction : mk_word

  task automatic chk_chan(input int c);
    logic [7:0] er;
    logic [7:0] eb;
    logic [11:0] m;
    m = (mode == 2'h3) ? 12'h0FF : (mode == 2'h2) ? 12'h3FF : 12'hFFF;
    for (int k = 0; k < 8; k++) begin
      er[k] = (c != 0) && (c <= int'(red_v[k] & m));
      eb[k] = (c != 0) && (c <= int'(blue_v[k] & m));
    end
    chk(cnt, c, "count");
    chk(red_o, er, "red enables");
    chk(blue_o, eb, "blue enables");
  endtask : chk_chan

  task automatic load();
    logic [287:0] w;
    w = mk_word();
    i_host.shift_word(w);
    i_host.pulse_latch();
    chk(serial_data_out, w[287], "top bit after latch");
  endtask : load

  task automatic t_reset();
    chk({cnt, red_o, blue_o, serial_data_out}, 0, "reset state");
    $display("test reset done");
  endtask : t_reset

  task automatic t_count();
    for (int k = 0; k < 8; k++) begin
      red_v[k] = 12'(k + 1);
      blue_v[k] = 12'(2 * k);
    end
    load();
    i_host.set_blank(1'b1);
    chk_chan(0);
    for (int c = 1; c <= 17; c++) begin
      i_host.grayscale_ref_clock_pulses(1);
      chk_chan(c);
    end
    $display("test count done");
  endtask : t_count

  // compares every bit that leaves while shifting nw in
  task automatic unload(input logic [287:0] ex, input logic [287:0] nw);
    for (int i = 287; i >= 0; i--) begin
      chk(serial_data_out, ex[i], "readback bit");
      i_host.shift_bit(nw[i]);
    end
  endtask : unload

  task automatic t_readback();
    logic [287:0] w;
    logic [287:0] nw;
    w = mk_word();
    for (int k = 0; k < 8; k++) begin
      red_v[k] = 12'h020;
      blue_v[k] = 12'h020;
    end
    nw = mk_word();
    unload({w[287:gspwm_pkg::CFG_W], cfg}, nw);
    $display("test readback done");
  endtask : t_readback

  task automatic t_relatch();
    i_host.pulse_latch();
    chk_chan(17);
    $display("test relatch done");
  endtask : t_relatch

  task automatic t_blank();
    i_host.set_blank(1'b0);
    chk_chan(0);
    i_host.grayscale_ref_clock_pulses(2);
    chk_chan(0);
    i_host.set_blank(1'b1);
    i_host.grayscale_ref_clock_pulses(1);
    chk_chan(1);
    i_host.set_blank(1'b0);
    $display("test blank done");
  endtask : t_blank

  task automatic t_mode8();
    mode = 2'h3;
    for (int k = 0; k < 8; k++) begin
      red_v[k] = 12'h101;
      blue_v[k] = 12'hEFF;
    end
    load();
    i_host.set_blank(1'b1);
    i_host.grayscale_ref_clock_pulses(1);
    chk_chan(1);
    i_host.grayscale_ref_clock_pulses(1);
    chk_chan(2);
    i_host.grayscale_ref_clock_pulses(253);
    chk_chan(255);
    i_host.grayscale_ref_clock_pulses(1);
    chk_chan(256);
    i_host.grayscale_ref_clock_pulses(2);
    chk_chan(256);
    $display("test mode8 done");
  endtask : t_mode8

  task automatic t_mode10();
    logic [287:0] w;
    i_host.set_blank(1'b0);
    mode = 2'h2;
    cfg = {41{5'h14}};
    for (int k = 0; k < 8; k++) begin
      red_v[k] = 12'h401;
      blue_v[k] = 12'hBFF;
    end
    w = mk_word();
    load();
    unload({w[287:gspwm_pkg::CFG_W], cfg}, w);
    i_host.set_blank(1'b1);
    i_host.grayscale_ref_clock_pulses(1);
    chk_chan(1);
    i_host.grayscale_ref_clock_pulses(1022);
    chk_chan(1023);
    i_host.grayscale_ref_clock_pulses(2);
    chk_chan(1024);
    $display("test mode10 done");
  endtask : t_mode10

  // reset in mid-run with channels on, released with blank, latch and clock pins low
  task automatic t_reset2();
    i_host.set_blank(1'b0);
    i_host.set_blank(1'b1);
    i_host.grayscale_ref_clock_pulses(1);
    chk_chan(1);
    sys_rst_i = 1'b1;
    i_host.set_blank(1'b0);
    chk({cnt, red_o, blue_o, serial_data_out}, 0, "state in reset");
    sys_rst_i = 1'b0;
    i_host.wait_cyc(2);
    for (int k = 0; k < 8; k++) begin
      red_v[k] = 12'h000;
      blue_v[k] = 12'h000;
    end
    i_host.set_blank(1'b1);
    i_host.grayscale_ref_clock_pulses(1);
    chk_chan(1);
    $display("test reset2 done");
  endtask : t_reset2

  initial begin
    repeat (90000) @(posedge core_clk_i);
    err_count++;
    $display("unexpected at %0t: run timed out", $time);
    finish_test();
  end

  initial begin
    err_count = 0;
    cmp_count = 0;
    sys_rst_i = 1'b1;
    mode = 2'h0;
    cfg = {41{5'h0B}};
    repeat (6) @(posedge core_clk_i);
    #1;
    sys_rst_i = 1'b0;
    i_host.wait_cyc(2);
    t_reset();
    t_count();
    t_readback();
    t_relatch();
    t_blank();
    t_mode8();
    t_mode10();
    t_reset2();
    finish_test();
  end
endmodule : grayscale_pwm_latch_tb_top
